// File: design/fpc_consts.svh
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// opcodes
`define FPC_OP_EN4       8'hb7
`define FPC_OP_EX4       8'he9
`define FPC_OP_DPD       8'hb9
`define FPC_OP_REL       8'hab
`define FPC_OP_RD_VL     8'he8
`define FPC_OP_WR_VL     8'he5
`define FPC_OP_RD_NVL    8'he2
`define FPC_OP_WR_NVL    8'he3
`define FPC_OP_ER_NVL    8'he4
`define FPC_OP_RD_FRZ    8'ha7
`define FPC_OP_WR_FRZ    8'ha6
`define FPC_OP_RD_PW     8'h27
`define FPC_OP_RD_VL4    8'he0
`define FPC_OP_WR_VL4    8'he1
`define FPC_OP_TRAIN     8'hcd
`define FPC_OP_RST_EN    8'h66
`define FPC_OP_RST_MEM   8'h99
`define FPC_OP_ID_A      8'h9e
`define FPC_OP_ID_B      8'h9f
`define FPC_OP_DISC      8'h5a

// address lengths and dummy counts
`define FPC_ALEN_3       3'd3
`define FPC_ALEN_4       3'd4
`define FPC_DUMMY_OCT    6'd8
`define FPC_DUMMY_DISC   6'd8
`define FPC_TRAIN_EXTRA  6'd2

// event toggle positions
`define FPC_EV_EN4       0
`define FPC_EV_EX4       1
`define FPC_EV_DPD       2
`define FPC_EV_REL       3
`define FPC_EV_FRZ       4
`define FPC_EV_VLW       5
`define FPC_EV_NVW       6
`define FPC_EV_NVE       7
`define FPC_EV_RST       8
`define FPC_EV_N         9

// reset recovery timing
`define FPC_CLK_NS       100
`define FPC_RST_NS       1000
`define FPC_RST_CYC      4'((`FPC_RST_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

// output constants, values arbitrary
`define FPC_TRAIN_PAT    8'h3c
`define FPC_ID0          8'h11
`define FPC_ID1          8'h22
`define FPC_ID2          8'h33
`define FPC_DISC_SIG     32'h44556677

`endif

// File: design/fpc_flash_cmd.sv
// What this block does
// - 4-byte mode commands single-lane only, octal forces 4
// - power-down enter and release are command-only
// - volatile lock read: variable address, octal 8 dummies
// - volatile lock write: variable address, one byte
// - nonvolatile lock read: 4 address bytes, octal dummies
// - nonvolatile lock write: 4 address bytes only
// - nonvolatile lock erase is command-only
// - freeze bit read out, set by command
// - password 64 bits, low byte first, repeats
// - 4-byte volatile lock read and write
// - training read: no address, configured dummies plus two
// - variable address is 4 bytes in 4-byte/octal
// - discovery read 3 address bytes, octal takes 4
// - software reset reloads power-on defaults
// - software reset aborts running or suspended operation
// - reset complete when flag bit 7 reads one
// - reset enable ignored during register writes
// - identification read undecoded while program/erase busy
// - chip select high ends output, back to standby
// - discovery data wraps at 256-byte boundary
`timescale 1ns/100ps
`default_nettype none
`include "fpc_consts.svh"

module fpc_flash_cmd
  import fpc_pkg::*;
(
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // serial link
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [7:0]  octal_data_lanes_rx,
  output logic      [7:0]  octal_data_lanes_tx,
  output logic      [7:0]  octal_data_lanes_oe,
  // configuration and device state
  input  wire logic        octal_ddr,
  input  wire logic [4:0]  octal_dummy,
  input  wire logic        prog_busy,
  input  wire logic        wrreg_busy,
  input  wire logic        def_addr4,
  input  wire logic [7:0]  def_vol_lock,
  input  wire logic [7:0]  nv_lock,
  input  wire logic [63:0] password,
  // status
  output logic             addr4_mode,
  output logic             deep_power_down,
  output logic             global_freeze,
  output logic      [7:0]  vol_lock,
  output logic             nvlock_write,
  output logic             nvlock_erase,
  output logic             sw_reset,
  output logic             op_abort,
  output logic             flag_ready
);

  fpc_lin_t     lin_raw;
  fpc_lin_t     li;
  fpc_cin_t     cin_raw;
  fpc_cin_t     ci;
  fpc_frame_t   f_q;
  fpc_frame_t   f_d;
  fpc_persist_t p_q;
  fpc_persist_t p_d;
  fpc_core_t    c_q;
  fpc_core_t    c_d;

  // ---------------- crossings ----------------

  // pins and core flops into the link domain; quasi-static, a change needs a few link edges
  assign lin_raw = '{rst_n: reset_n, octal: octal_ddr, dcfg: octal_dummy,
                     busy_prog: prog_busy, busy_wr: wrreg_busy,
                     nvlock: nv_lock, pword: password, addr4: c_q.addr4,
                     dpd: c_q.dpd, frz: c_q.frz, vlock: c_q.vlock};

  fpc_sync #(.W($bits(fpc_lin_t))) u_sync_link (
    .clk (sclk),
    .d   (lin_raw),
    .q   (li)
  );

  // frame end, straps and event toggles into the core domain
  assign cin_raw = '{cs_n: cs_n, busy: prog_busy | wrreg_busy,
                     def_addr4: def_addr4, def_vlock: def_vol_lock,
                     tog: p_q.tog};

  fpc_sync #(.W($bits(fpc_cin_t))) u_sync_core (
    .clk (clk),
    .d   (cin_raw),
    .q   (ci)
  );

  // ---------------- link domain ----------------

  // byte served on output phases; address doubles as the byte index
  function automatic logic [7:0] src_byte(input logic [7:0]  op,
                                          input logic [31:0] a,
                                          input fpc_lin_t    l);
    logic [7:0] b;
    b = 8'hff;
    case (op)
      `FPC_OP_RD_VL, `FPC_OP_RD_VL4: b = l.vlock;
      `FPC_OP_RD_NVL: b = l.nvlock;
      `FPC_OP_RD_FRZ: b = {7'h00, l.frz};
      `FPC_OP_RD_PW:  b = l.pword[{a[2:0], 3'b000} +: 8];
      `FPC_OP_TRAIN:  b = `FPC_TRAIN_PAT;
      `FPC_OP_ID_A, `FPC_OP_ID_B: begin
        unique case (a[1:0])
          2'd0:    b = `FPC_ID0;
          2'd1:    b = `FPC_ID1;
          2'd2:    b = `FPC_ID2;
          default: b = 8'h00;
        endcase
      end
      // only the low address byte indexes the table
      `FPC_OP_DISC: begin
        if (a[7:2] == 6'h00) begin
          b = 8'(`FPC_DISC_SIG >> {~a[1:0], 3'b000});
        end
      end
      default: b = 8'hff;
    endcase
    return b;
  endfunction : src_byte

  logic [7:0]          nb;
  logic                bdone;
  logic                oct;
  logic                go;
  logic                adv;
  logic                load;
  logic [2:0]          alen;
  logic [5:0]          rdum;
  logic [7:0]          ob;
  logic [`FPC_EV_N-1:0] ev;

  // command, address, dummy and data phases of one frame
  always_comb begin
    f_d  = f_q;
    p_d  = p_q;
    ev   = '0;
    go   = 1'b0;
    adv  = 1'b0;
    load = 1'b0;
    ob   = 8'h00;
    oct  = li.octal;
    // one byte per edge on eight lanes, one bit per edge on lane zero
    nb    = oct ? octal_data_lanes_rx : {f_q.sh[6:0], octal_data_lanes_rx[0]};
    bdone = oct || (f_q.bitn == 3'd7);
    f_d.sh   = nb;
    f_d.bitn = oct ? 3'd0 : f_q.bitn + 3'd1;
    alen = (oct || li.addr4) ? `FPC_ALEN_4 : `FPC_ALEN_3;
    rdum = oct ? `FPC_DUMMY_OCT : 6'd0;
    unique case (f_q.st)
      st_cmd: begin
        if (bdone) begin
          f_d.cmd   = nb;
          f_d.st    = st_ignore;
          p_d.armed = 1'b0;
          // power-down answers only its release
          if (!li.dpd || nb == `FPC_OP_REL) begin
            case (nb)
              `FPC_OP_EN4: begin
                if (!oct) ev[`FPC_EV_EN4] = 1'b1;
              end
              `FPC_OP_EX4: begin
                if (!oct) ev[`FPC_EV_EX4] = 1'b1;
              end
              `FPC_OP_DPD:    ev[`FPC_EV_DPD] = 1'b1;
              `FPC_OP_REL:    ev[`FPC_EV_REL] = 1'b1;
              `FPC_OP_ER_NVL: ev[`FPC_EV_NVE] = 1'b1;
              `FPC_OP_WR_FRZ: ev[`FPC_EV_FRZ] = 1'b1;
              `FPC_OP_RD_VL: begin
                f_d.nadr = alen;
                f_d.dcnt = rdum;
                f_d.rd   = 1'b1;
                go       = 1'b1;
              end
              `FPC_OP_RD_VL4, `FPC_OP_RD_NVL: begin
                f_d.nadr = `FPC_ALEN_4;
                f_d.dcnt = rdum;
                f_d.rd   = 1'b1;
                go       = 1'b1;
              end
              `FPC_OP_WR_VL: begin
                f_d.nadr = alen;
                f_d.wr   = 1'b1;
                go       = 1'b1;
              end
              `FPC_OP_WR_VL4: begin
                f_d.nadr = `FPC_ALEN_4;
                f_d.wr   = 1'b1;
                go       = 1'b1;
              end
              `FPC_OP_WR_NVL: begin
                f_d.nadr = `FPC_ALEN_4;
                go       = 1'b1;
              end
              `FPC_OP_RD_FRZ, `FPC_OP_RD_PW: begin
                f_d.dcnt = rdum;
                f_d.rd   = 1'b1;
                go       = 1'b1;
              end
              `FPC_OP_TRAIN: begin
                f_d.dcnt = {1'b0, li.dcfg} + `FPC_TRAIN_EXTRA;
                f_d.rd   = 1'b1;
                go       = 1'b1;
              end
              `FPC_OP_ID_A, `FPC_OP_ID_B: begin
                if (!li.busy_prog) begin
                  f_d.rd = 1'b1;
                  go     = 1'b1;
                end
              end
              `FPC_OP_DISC: begin
                f_d.nadr = oct ? `FPC_ALEN_4 : `FPC_ALEN_3;
                f_d.dcnt = `FPC_DUMMY_DISC;
                f_d.rd   = 1'b1;
                go       = 1'b1;
              end
              // enable is dropped by any other command in between
              `FPC_OP_RST_EN: p_d.armed = !li.busy_wr;
              `FPC_OP_RST_MEM: begin
                if (p_q.armed) ev[`FPC_EV_RST] = 1'b1;
              end
              default: f_d.st = st_ignore;
            endcase
          end
        end
      end
      st_addr: begin
        if (bdone) begin
          f_d.addr = {f_q.addr[23:0], nb};
          f_d.nadr = f_q.nadr - 3'd1;
          if (f_q.nadr == 3'd1) begin
            if (f_q.cmd == `FPC_OP_WR_NVL) ev[`FPC_EV_NVW] = 1'b1;
            adv = 1'b1;
          end
        end
      end
      st_dummy: begin
        f_d.dcnt = f_q.dcnt - 6'd1;
        if (f_q.dcnt == 6'd1) adv = 1'b1;
      end
      // exactly one byte is taken, the rest of the frame is ignored
      st_din: begin
        if (bdone) begin
          p_d.wdata         = nb;
          ev[`FPC_EV_VLW]   = 1'b1;
          f_d.st            = st_ignore;
        end
      end
      // continuous output until chip select rises
      st_dout: begin
        if (oct || f_q.obit == 3'd7) begin
          load = 1'b1;
        end else begin
          f_d.lane = {6'h00, f_q.osh[7], 1'b0};
          f_d.osh  = {f_q.osh[6:0], 1'b0};
          f_d.obit = f_q.obit + 3'd1;
        end
      end
      st_ignore: f_d.st = st_ignore;
    endcase
    // leave the opcode phase
    if (go) begin
      if (f_d.nadr != 3'd0) begin
        f_d.st = st_addr;
      end else begin
        adv = 1'b1;
      end
    end
    // pick the phase after address or dummies
    if (adv) begin
      if (f_d.dcnt != 6'd0) begin
        f_d.st = st_dummy;
      end else if (f_d.rd) begin
        f_d.st = st_dout;
        load   = 1'b1;
      end else if (f_d.wr) begin
        f_d.st = st_din;
      end else begin
        f_d.st = st_ignore;
      end
    end
    // present the next byte, index steps once per byte
    if (load) begin
      ob = src_byte(f_d.cmd, f_d.addr, li);
      if (f_d.cmd == `FPC_OP_DISC) begin
        f_d.addr[7:0] = f_d.addr[7:0] + 8'h01;
      end else begin
        f_d.addr = f_d.addr + 32'h1;
      end
      if (oct) begin
        f_d.lane = ob;
        f_d.oe   = 8'hff;
      end else begin
        f_d.lane = {6'h00, ob[7], 1'b0};
        f_d.oe   = 8'h02;
        f_d.osh  = {ob[6:0], 1'b0};
        f_d.obit = 3'd0;
      end
    end
    p_d.tog = p_q.tog ^ ev;
  end

  // frame state dies with chip select, which also floats the lanes
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      f_q <= fpc_frame_t'('0);
    end else begin
      f_q <= f_d;
    end
  end

  // toggles survive frames; the core side re-aligns at its own reset
  always_ff @(posedge sclk) begin
    if (!li.rst_n) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  // ---------------- core domain ----------------

  logic [`FPC_EV_N-1:0] cev;

  always_comb begin
    c_d       = c_q;
    cev       = ci.tog ^ c_q.seen;
    c_d.seen  = ci.tog;
    c_d.nvw   = cev[`FPC_EV_NVW];
    c_d.nve   = cev[`FPC_EV_NVE];
    c_d.swr   = 1'b0;
    c_d.abort = 1'b0;
    if (cev[`FPC_EV_EN4]) c_d.addr4 = 1'b1;
    if (cev[`FPC_EV_EX4]) c_d.addr4 = 1'b0;
    if (cev[`FPC_EV_DPD]) c_d.dpd = 1'b1;
    if (cev[`FPC_EV_REL]) c_d.dpd = 1'b0;
    if (cev[`FPC_EV_FRZ]) c_d.frz = 1'b1;
    // frozen lock bits refuse volatile writes; wdata is stable by now
    if (cev[`FPC_EV_VLW] && !c_q.frz) c_d.vlock = p_q.wdata;
    if (cev[`FPC_EV_RST]) c_d.pend = 1'b1;
    // reset takes effect only once chip select is high again
    if (c_q.pend && ci.cs_n) begin
      c_d.pend  = 1'b0;
      c_d.addr4 = ci.def_addr4;
      c_d.vlock = ci.def_vlock;
      c_d.frz   = 1'b0;
      c_d.dpd   = 1'b0;
      c_d.swr   = 1'b1;
      c_d.abort = ci.busy;
      c_d.ready = 1'b0;
      c_d.rcnt  = `FPC_RST_CYC;
    end else if (c_q.rcnt != 4'd0) begin
      c_d.rcnt = c_q.rcnt - 4'd1;
      if (c_q.rcnt == 4'd1) c_d.ready = 1'b1;
    end
    if (!reset_n) begin
      c_d = '{seen: ci.tog, addr4: ci.def_addr4, vlock: ci.def_vlock,
              ready: 1'b1, default: '0};
    end
  end

  always_ff @(posedge clk) begin
    c_q <= c_d;
  end

  // outputs straight from flops
  assign octal_data_lanes_tx = f_q.lane;
  assign octal_data_lanes_oe = f_q.oe;
  assign addr4_mode          = c_q.addr4;
  assign deep_power_down     = c_q.dpd;
  assign global_freeze       = c_q.frz;
  assign vol_lock            = c_q.vlock;
  assign nvlock_write        = c_q.nvw;
  assign nvlock_erase        = c_q.nve;
  assign sw_reset            = c_q.swr;
  assign op_abort            = c_q.abort;
  assign flag_ready          = c_q.ready;

endmodule : fpc_flash_cmd

`default_nettype wire

// File: design/fpc_pkg.sv
package fpc_pkg;

  typedef enum logic [2:0] {
    st_cmd,
    st_addr,
    st_dummy,
    st_dout,
    st_din,
    st_ignore
  } fpc_state_t;

  // per-frame link state, cleared by chip select high
  typedef struct packed {
    fpc_state_t  st;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic [7:0]  cmd;
    logic [2:0]  nadr;
    logic [31:0] addr;
    logic [5:0]  dcnt;
    logic        rd;
    logic        wr;
    logic [7:0]  osh;
    logic [2:0]  obit;
    logic [7:0]  lane;
    logic [7:0]  oe;
  } fpc_frame_t;

  // link state kept across frames
  typedef struct packed {
    logic [8:0] tog;
    logic [7:0] wdata;
    logic       armed;
  } fpc_persist_t;

  // inputs seen by the link domain
  typedef struct packed {
    logic        rst_n;
    logic        octal;
    logic [4:0]  dcfg;
    logic        busy_prog;
    logic        busy_wr;
    logic [7:0]  nvlock;
    logic [63:0] pword;
    logic        addr4;
    logic        dpd;
    logic        frz;
    logic [7:0]  vlock;
  } fpc_lin_t;

  // inputs seen by the core domain
  typedef struct packed {
    logic       cs_n;
    logic       busy;
    logic       def_addr4;
    logic [7:0] def_vlock;
    logic [8:0] tog;
  } fpc_cin_t;

  typedef struct packed {
    logic [8:0] seen;
    logic       addr4;
    logic       dpd;
    logic       frz;
    logic [7:0] vlock;
    logic       pend;
    logic [3:0] rcnt;
    logic       ready;
    logic       nvw;
    logic       nve;
    logic       swr;
    logic       abort;
  } fpc_core_t;

endpackage : fpc_pkg

// File: design/fpc_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser, second stage is the only reader of the first
module fpc_sync #(
  parameter int W = 1
) (
  // clock of the receiving domain
  input  wire logic         clk,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [1:0][W-1:0] s_q;
  logic [1:0][W-1:0] s_d;

  // shift through both stages
  always_comb begin
    s_d[0] = d;
    s_d[1] = s_q[0];
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign q = s_q[1];

endmodule : fpc_sync

`default_nettype wire

// File: testbench/flash_protect_reset_id_cmds_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "fpc_consts.svh"
module flash_protect_reset_id_cmds_test;
  // design pins
  logic        clk, reset_n, sclk, cs_n, octal_ddr, prog_busy, wrreg_busy, def_addr4;
  logic [7:0]  rx, tx, oe, def_vol_lock, nv_lock, vol_lock;
  logic [4:0]  octal_dummy;
  logic [63:0] password, rd, pw_exp;
  logic        addr4_mode, deep_power_down, global_freeze, nvlock_write, nvlock_erase;
  logic        sw_reset, op_abort, flag_ready;
  // bookkeeping
  int          miscompares, check_count, cycles, nvw_n, nve_n, swr_n, abt_n;

  fpc_flash_cmd uut (
    .clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .octal_data_lanes_rx(rx),
    .octal_data_lanes_tx(tx), .octal_data_lanes_oe(oe), .octal_ddr(octal_ddr), .octal_dummy(octal_dummy),
    .prog_busy(prog_busy), .wrreg_busy(wrreg_busy), .def_addr4(def_addr4), .def_vol_lock(def_vol_lock),
    .nv_lock(nv_lock), .password(password), .addr4_mode(addr4_mode), .deep_power_down(deep_power_down),
    .global_freeze(global_freeze), .vol_lock(vol_lock), .nvlock_write(nvlock_write),
    .nvlock_erase(nvlock_erase), .sw_reset(sw_reset), .op_abort(op_abort), .flag_ready(flag_ready)
  );
  fpc_host_model host (.sclk(sclk), .cs_n(cs_n), .rx(rx), .tx(tx), .oe(oe), .oct(octal_ddr));

  task automatic stop_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one frame, then time for its event to reach the core
  task automatic run(input logic [63:0] t, input int nb, nd, nr);
    host.xfer(t, nb, nd, nr, rd);
    if (nr > 0) chk("latency", 64'(nb * (octal_ddr ? 1 : 8) + nd), 64'(host.first_oe));
    repeat (8) @(posedge clk);
  endtask : run

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // pulse tallies and hang guard
  always @(posedge clk) begin
    if (nvlock_write === 1'b1) nvw_n++;
    if (nvlock_erase === 1'b1) nve_n++;
    if (sw_reset === 1'b1) swr_n++;
    if (op_abort === 1'b1) abt_n++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    octal_ddr = 1'b0;
    octal_dummy = 5'd16;
    prog_busy = 1'b0;
    wrreg_busy = 1'b0;
    def_addr4 = 1'b0;
    def_vol_lock = 8'h3a;
    nv_lock = 8'hc5;
    password = 64'h0123456789abcdef;
    for (int k = 0; k < 8; k++) pw_exp[63 - 8 * k -: 8] = password[8 * k +: 8];
    fork
      host.clocks(3);
      repeat (4) @(posedge clk);
    join
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("defaults", 12'h13a, {addr4_mode, deep_power_down, global_freeze, flag_ready, vol_lock});
    // single-lane lock, address and table reads
    run({8'he8, 56'h0}, 4, 0, 2);
    chk("vl_read", 16'h3a3a, rd);
    run({8'hb7, 56'h0}, 1, 0, 0);
    chk("addr4_on", 1'b1, addr4_mode);
    run({8'he8, 56'h0}, 5, 0, 1);
    chk("vl_read_a4", 8'h3a, rd);
    run({8'h5a, 24'h0000fe, 32'h0}, 4, 8, 6);
    chk("disc_wrap", {16'hffff, `FPC_DISC_SIG}, rd);
    run({8'he9, 56'h0}, 1, 0, 0);
    chk("addr4_off", 1'b0, addr4_mode);
    run({8'he5, 24'h0, 8'ha5, 24'h0}, 5, 0, 0);
    chk("vl_write", 8'ha5, vol_lock);
    run({8'he1, 32'h0, 8'h5a, 16'h0}, 6, 0, 0);
    chk("vl_write4", 8'h5a, vol_lock);
    run({8'he0, 56'h0}, 5, 0, 1);
    chk("vl_read4", 8'h5a, rd);
    run({8'he2, 56'h0}, 5, 0, 2);
    chk("nvl_read", 16'hc5c5, rd);
    run({8'he3, 56'h0}, 5, 0, 0);
    run({8'he4, 56'h0}, 1, 0, 0);
    chk("nvl_pulses", 64'h0000000100000001, {nvw_n, nve_n});
    run({8'h27, 56'h0}, 1, 0, 16);
    chk("password", pw_exp, rd);
    $display("test single lane done");
    // freeze, identification and refused frames
    run({8'ha6, 56'h0}, 1, 0, 0);
    run({8'he5, 24'h0, 8'h00, 24'h0}, 5, 0, 0);
    chk("frozen", 9'h15a, {global_freeze, vol_lock});
    run({8'ha7, 56'h0}, 1, 0, 1);
    chk("frz_read", 8'h01, rd);
    run({8'h9f, 56'h0}, 1, 0, 5);
    chk("id", {`FPC_ID0, `FPC_ID1, `FPC_ID2, 8'h00, `FPC_ID0}, rd);
    run({8'h9e, 56'h0}, 1, 0, 1);
    chk("id_alt", `FPC_ID0, rd);
    run({8'h00, 56'h0}, 1, 16, 0);
    chk("unknown_quiet", 8'h00, host.oe_or);
    run({8'hb9, 56'h0}, 1, 0, 0);
    run({8'h9f, 56'h0}, 1, 16, 0);
    chk("dpd_quiet", 9'h100, {deep_power_down, host.oe_or});
    run({8'hab, 56'h0}, 1, 0, 0);
    chk("dpd_off", 1'b0, deep_power_down);
    prog_busy <= 1'b1;
    run({8'h9f, 56'h0}, 1, 16, 0);
    chk("id_busy", 8'h00, host.oe_or);
    chk("idle_lanes", 8'h00, oe);
    $display("test freeze and id done");
    // octal protocol
    octal_ddr <= 1'b1;
    repeat (4) @(posedge clk);
    host.clocks(3);
    run({8'he8, 56'h0}, 5, 8, 2);
    chk("o_vl_read", 16'h5a5a, rd);
    run({8'hcd, 56'h0}, 1, 18, 2);
    chk("train", {2{`FPC_TRAIN_PAT}}, rd);
    octal_dummy <= 5'd10;
    repeat (4) @(posedge clk);
    host.clocks(3);
    run({8'hcd, 56'h0}, 1, 12, 1);
    chk("train_cfg", `FPC_TRAIN_PAT, rd);
    run({8'h27, 56'h0}, 1, 8, 9);
    chk("o_password", {pw_exp[55:0], pw_exp[63:56]}, rd);
    run({8'h5a, 32'h00000002, 24'h0}, 5, 8, 3);
    chk("o_disc", 24'h6677ff, rd);
    run({8'hb7, 56'h0}, 1, 0, 0);
    chk("o_addr4_refused", 1'b0, addr4_mode);
    $display("test octal done");
    // software reset, first blocked by a register write
    octal_ddr <= 1'b0;
    wrreg_busy <= 1'b1;
    repeat (4) @(posedge clk);
    host.clocks(3);
    run({8'h66, 56'h0}, 1, 0, 0);
    run({8'h99, 56'h0}, 1, 0, 0);
    chk("rst_refused", 0, swr_n);
    wrreg_busy <= 1'b0;
    repeat (4) @(posedge clk);
    run({8'h66, 56'h0}, 1, 0, 0);
    run({8'h99, 56'h0}, 1, 0, 0);
    for (int i = 0; i < 40 && flag_ready !== 1'b1; i++) @(posedge clk);
    chk("rst_counts", 64'h0000000100000001, {swr_n, abt_n});
    chk("rst_state", 12'h13a, {addr4_mode, deep_power_down, global_freeze, flag_ready, vol_lock});
    $display("test soft reset done");
    stop_test();
  end
endmodule : flash_protect_reset_id_cmds_test
`default_nettype wire

// File: testbench/fpc_flash_cmd_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_cmd_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // link and configuration
  input wire logic       cs_n,
  input wire logic [7:0] octal_data_lanes_oe,
  input wire logic       octal_ddr,
  input wire logic       prog_busy,
  input wire logic       def_addr4,
  input wire logic [7:0] def_vol_lock,
  // device state
  input wire logic       addr4_mode,
  input wire logic       deep_power_down,
  input wire logic       global_freeze,
  input wire logic [7:0] vol_lock,
  input wire logic       nvlock_write,
  input wire logic       nvlock_erase,
  input wire logic       sw_reset,
  input wire logic       op_abort,
  input wire logic       flag_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // busy window after a software reset, then ready again
  sequence s_recover;
    !flag_ready [*6] ##[1:8] flag_ready;
  endsequence
  property p_idle; cs_n |-> octal_data_lanes_oe == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("lanes driven while deselected");
  property p_width; octal_data_lanes_oe != 8'h00 |-> octal_data_lanes_oe == (octal_ddr ? 8'hff : 8'h02); endproperty
  a_width: assert property (p_width) else $error("wrong lane set driven");
  property p_reload;
    sw_reset |=> vol_lock == def_vol_lock && addr4_mode == def_addr4 && !global_freeze && !deep_power_down;
  endproperty
  a_reload: assert property (p_reload) else $error("defaults not reloaded");
  property p_recover; $rose(sw_reset) |-> ##2 s_recover; endproperty
  a_recover: assert property (p_recover) else $error("ready flag timing wrong");
  property p_abort_with; op_abort |-> sw_reset; endproperty
  a_abort_with: assert property (p_abort_with) else $error("abort without reset");
  property p_abort_busy; sw_reset && prog_busy && $past(prog_busy, 4) |-> op_abort; endproperty
  a_abort_busy: assert property (p_abort_busy) else $error("busy operation not aborted");
  property p_frz_hold; global_freeze |=> global_freeze || sw_reset; endproperty
  a_frz_hold: assert property (p_frz_hold) else $error("freeze bit lost");
  property p_vl_frozen; global_freeze && $past(global_freeze) |-> $stable(vol_lock) || sw_reset; endproperty
  a_vl_frozen: assert property (p_vl_frozen) else $error("lock changed while frozen");
  property p_nvw; nvlock_write |=> !nvlock_write [*3]; endproperty
  a_nvw: assert property (p_nvw) else $error("write pulse too long");
  property p_nve; nvlock_erase |=> !nvlock_erase [*3]; endproperty
  a_nve: assert property (p_nve) else $error("erase pulse too long");
  property p_oct_a4; octal_ddr && $past(octal_ddr) |-> $stable(addr4_mode) || sw_reset; endproperty
  a_oct_a4: assert property (p_oct_a4) else $error("address mode changed in octal");
endmodule : fpc_flash_cmd_sva

bind fpc_flash_cmd fpc_flash_cmd_sva u_sva (
  .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .octal_data_lanes_oe(octal_data_lanes_oe),
  .octal_ddr(octal_ddr), .prog_busy(prog_busy), .def_addr4(def_addr4), .def_vol_lock(def_vol_lock),
  .addr4_mode(addr4_mode), .deep_power_down(deep_power_down), .global_freeze(global_freeze),
  .vol_lock(vol_lock), .nvlock_write(nvlock_write), .nvlock_erase(nvlock_erase),
  .sw_reset(sw_reset), .op_abort(op_abort), .flag_ready(flag_ready)
);
`default_nettype wire

// File: testbench/fpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host controller: link clock runs inside frames and in bare bursts with chip select high
module fpc_host_model (
  // link pins
  output logic            sclk,
  output logic            cs_n,
  output logic      [7:0] rx,
  input  wire logic [7:0] tx,
  input  wire logic [7:0] oe,
  // protocol select
  input  wire logic       oct
);
  logic [7:0] oe_or;
  int         first_oe;
  int         e;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    rx = 8'h00;
  end
  // one link clock; lanes sampled just before the rise
  task automatic tick(input logic [7:0] d, output logic [7:0] s);
    rx = d;
    #40;
    s = tx;
    oe_or = oe_or | oe;
    if (oe !== 8'h00 && first_oe < 0) first_oe = e;
    e++;
    sclk = 1'b1;
    #40;
    sclk = 1'b0;
  endtask : tick
  // one frame; freed lanes toggle so stale data never looks valid
  task automatic xfer(input logic [63:0] t, input int nb, nd, nr, output logic [63:0] rd);
    logic [7:0] s;
    int w;
    w = oct ? 1 : 8;
    rd = '0;
    oe_or = 8'h00;
    first_oe = -1;
    e = 0;
    cs_n = 1'b0;
    for (int i = 0; i < nb * w; i++) tick(oct ? t[63 - 8 * i -: 8] : {~rx[7:1], t[63 - i]}, s);
    repeat (nd) tick(~rx, s);
    for (int i = 0; i < nr * w; i++) begin
      tick(~rx, s);
      rd = oct ? {rd[55:0], s} : {rd[62:0], s[1]};
    end
    #40;
    cs_n = 1'b1;
    #400;
  endtask : xfer
  // bare clocks with chip select high; link-side synchronisers only move on link edges
  task automatic clocks(input int n);
    logic [7:0] s;
    repeat (n) tick(rx, s);
  endtask : clocks
endmodule : fpc_host_model
`default_nettype wire
